// File: rtl/generator_autostart_controller.sv
`timescale 1ns/1ps
`include "gen_defs.svh"

module generator_autostart_controller #(
    parameter int TICK_CYCLES = `SEC_CYCLES
) (
    input wire logic i_clk, // 100 MHz clock
    input wire logic i_reset_n, // async reset, active low
    input wire gen_pkg::gen_ctrl_t i_gen_ctrl, // operator off/on/auto
    input wire gen_pkg::run_mode_t i_run_mode, // run relay mode
    input wire gen_pkg::inv_state_t i_inv_state, // inverter state
    input wire gen_pkg::aux_mode_t i_aux_mode, // aux fault relay mode
    input wire logic [15:0] i_load_amps, // measured load current
    input wire logic [15:0] i_load_start_amps, // load start threshold
    input wire logic [7:0] i_load_start_min, // load start delay, minutes
    input wire logic [7:0] i_load_stop_min, // load stop delay, minutes
    input wire logic [15:0] i_batt_mv, // battery voltage
    input wire logic [15:0] i_batt_lvl0, // 24 h start level
    input wire logic [15:0] i_batt_lvl1, // 2 h start level
    input wire logic [15:0] i_batt_lvl2, // 15 min start level
    input wire logic [15:0] i_batt_lvl3, // cutout level, 30 s
    input wire logic [10:0] i_tod_min, // time of day, minutes
    input wire logic [10:0] i_daily_start_min, // daily start time
    input wire logic [10:0] i_daily_stop_min, // daily stop time
    input wire logic [10:0] i_quiet_begin_min, // quiet begin time
    input wire logic [10:0] i_quiet_end_min, // quiet end time
    input wire logic [7:0] i_exercise_days, // exercise period, 0 = off
    input wire logic [7:0] i_exercise_min, // exercise run length
    input wire logic [7:0] i_cooldown_min, // cooldown length
    input wire logic [10:0] i_max_run_min, // max run time
    input wire logic i_gen_sensed, // generator input has voltage
    input wire logic i_grid_present, // grid input has a source
    input wire logic i_charge_done, // bulk and absorption complete
    output logic o_gen_run_relay, // run relay energized
    output logic o_aux_fault_relay, // aux fault relay energized
    output logic o_manual_start, // manual start indicator
    output logic o_charge_enable, // charger allowed
    output logic o_cooling, // cooldown in progress
    output logic o_running, // generator considered running
    output logic o_start_failed, // all attempts used up
    output gen_pkg::reason_t o_reason // why the generator runs
);
    import gen_pkg::*;

    tmr_if tmr();

    gen_timer_bank u_bank (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .bus(tmr.bank)
    );

    // ==========================================================
    // second tick
    logic [31:0] div_cnt;
    logic [31:0] next_div_cnt;
    logic sec_tick;

    // one enable pulse per second, phase, run time and hold timers count on it; the day count steps at midnight
    always_comb
    begin
        sec_tick = (div_cnt == 32'(TICK_CYCLES - 1));
        next_div_cnt = sec_tick ? 32'h00000000 : div_cnt + 32'h00000001;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            div_cnt <= 32'h00000000;
        else
            div_cnt <= next_div_cnt;
    end

    // ==========================================================
    // hold timer wiring
    always_comb
    begin
        tmr.tick = sec_tick;
        tmr.cond[0] = i_batt_mv <= i_batt_lvl0;
        tmr.cond[1] = i_batt_mv <= i_batt_lvl1;
        tmr.cond[2] = i_batt_mv <= i_batt_lvl2;
        tmr.cond[3] = i_batt_mv <= i_batt_lvl3;
        tmr.cond[`TMR_LOAD_HI] = i_load_amps > i_load_start_amps;
        tmr.cond[`TMR_LOAD_LO] = i_load_amps < i_load_start_amps;
        tmr.limit[0] = `LVL0_HOLD_SEC;
        tmr.limit[1] = `LVL1_HOLD_SEC;
        tmr.limit[2] = `LVL2_HOLD_SEC;
        tmr.limit[3] = `LVL3_HOLD_SEC;
        tmr.limit[`TMR_LOAD_HI] = 20'(i_load_start_min) * 20'(`SEC_PER_MIN);
        tmr.limit[`TMR_LOAD_LO] = 20'(i_load_stop_min) * 20'(`SEC_PER_MIN);
    end

    // ==========================================================
    // time of day events
    logic [10:0] prev_tod;
    logic min_edge;
    logic quiet;
    logic [10:0] start_q;
    logic [10:0] stop_q;
    logic midnight;

    // daily start and stop settings are honoured only on ten-minute marks
    always_comb
    begin
        min_edge = (i_tod_min != prev_tod);
        midnight = min_edge && (i_tod_min == 11'h000);
        start_q = i_daily_start_min - (i_daily_start_min % `STEP_MIN);
        stop_q = i_daily_stop_min - (i_daily_stop_min % `STEP_MIN);
        // equal begin and end switch quiet time off
        if (i_quiet_begin_min == i_quiet_end_min)
            quiet = 1'b0;
        else if (i_quiet_begin_min < i_quiet_end_min)
            quiet = i_tod_min >= i_quiet_begin_min && i_tod_min < i_quiet_end_min;
        else
            quiet = i_tod_min >= i_quiet_begin_min || i_tod_min < i_quiet_end_min;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            prev_tod <= 11'h000;
        else
            prev_tod <= i_tod_min;
    end

    // ==========================================================
    // start requests
    logic src_ok;
    logic load_req;
    logic batt_req;
    logic daily_req;
    logic ex_req;
    logic auto_go;
    logic [2:0] try_limit;
    reason_t auto_why;
    logic [7:0] day_cnt;

    always_comb
    begin
        src_ok = !((i_inv_state == INV_OFF || i_inv_state == INV_BYPASS)
                   && i_run_mode != MODE_UNMON_RUN);
        load_req = src_ok && !quiet && tmr.done[`TMR_LOAD_HI];
        batt_req = src_ok && ((!quiet && |tmr.done[2:0]) || tmr.done[3]);
        daily_req = src_ok && !quiet && min_edge && i_tod_min == start_q;
        ex_req = i_exercise_days != 8'h00 && day_cnt >= i_exercise_days
                 && min_edge && i_tod_min == i_quiet_end_min;
        auto_go = load_req || batt_req || daily_req || ex_req;
        if (ex_req)
            auto_why = WHY_EXERCISE;
        else if (batt_req)
            auto_why = WHY_BATT;
        else if (load_req)
            auto_why = WHY_LOAD;
        else
            auto_why = WHY_DAILY;
        try_limit = (i_run_mode == MODE_UNMON_RUN) ? `TRIES_UNMON : `TRIES_MON;
    end

    // ==========================================================
    // run sequencer
    gen_state_t state;
    gen_state_t next_state;
    reason_t why;
    reason_t next_why;
    logic [19:0] phase;
    logic [19:0] next_phase;
    logic [19:0] run_sec;
    logic [19:0] next_run_sec;
    logic [2:0] tries;
    logic [2:0] next_tries;
    logic failed;
    logic next_failed;
    logic [7:0] next_day_cnt;
    logic handover;
    logic next_handover;
    logic is_auto;
    logic max_hit;
    logic go_cool;
    logic go_stop;

    always_comb
    begin
        next_state = state;
        next_why = why;
        next_tries = tries;
        next_failed = failed;
        next_handover = handover;
        next_phase = (sec_tick && phase != 20'hfffff) ? phase + 20'h00001 : phase;
        next_run_sec = run_sec;
        next_day_cnt = day_cnt;
        is_auto = why != WHY_MANUAL && why != WHY_NONE;
        max_hit = run_sec >= 20'(i_max_run_min) * 20'(`SEC_PER_MIN);
        go_cool = 1'b0;
        go_stop = 1'b0;
        if (midnight && day_cnt != 8'hff)
            next_day_cnt = day_cnt + 8'h01;
        if (state == ST_RUN || state == ST_COOL)
        begin
            if (sec_tick)
                next_run_sec = run_sec + 20'h00001;
            // a five minute run proves the set, the exercise clock restarts
            if (sec_tick && next_run_sec == `RUN_RESET_SEC)
                next_day_cnt = 8'h00;
        end
        // stop decisions while running
        if (state == ST_RUN)
        begin
            unique case (why)
                WHY_MANUAL:
                begin
                    if (i_gen_ctrl == CTRL_AUTO)
                        next_handover = 1'b1;
                    go_cool = handover && i_charge_done;
                end
                WHY_LOAD: go_cool = tmr.done[`TMR_LOAD_LO];
                WHY_BATT:
                    if (i_run_mode == MODE_UNMON_RUN)
                        go_cool = max_hit;
                    else
                        go_cool = max_hit || i_charge_done;
                WHY_DAILY: go_cool = min_edge && i_tod_min == stop_q;
                WHY_EXERCISE:
                    go_stop = run_sec >= 20'(i_exercise_min) * 20'(`SEC_PER_MIN);
                WHY_NONE: go_stop = 1'b1;
            endcase
            if (is_auto && why != WHY_EXERCISE)
            begin
                if (i_grid_present && i_run_mode != MODE_UNMON_RUN)
                    go_cool = 1'b1;
                if (min_edge && i_tod_min == i_quiet_begin_min)
                    go_cool = 1'b1;
            end
        end
        unique case (state)
            ST_IDLE:
            begin
                next_run_sec = 20'h00000;
                next_handover = 1'b0;
                if (i_gen_ctrl == CTRL_OFF)
                begin
                    next_failed = 1'b0;
                    next_tries = 3'h0;
                end
                if (i_gen_ctrl == CTRL_ON)
                begin
                    next_state = ST_START;
                    next_why = WHY_MANUAL;
                    next_tries = 3'h1;
                    next_failed = 1'b0;
                    next_phase = 20'h00000;
                end
                else if (i_gen_ctrl == CTRL_AUTO && !failed && auto_go)
                begin
                    next_state = ST_START;
                    next_why = auto_why;
                    next_tries = 3'h1;
                    next_phase = 20'h00000;
                    if (auto_why == WHY_EXERCISE)
                        next_day_cnt = 8'h00;
                end
                else
                    next_why = WHY_NONE;
            end
            ST_START:
            begin
                // unmonitored sets give no feedback, assume it caught
                if (i_run_mode == MODE_UNMON_RUN || i_gen_sensed)
                begin
                    next_state = ST_RUN;
                    next_phase = 20'h00000;
                end
                else if (phase >= `ATTEMPT_SEC)
                begin
                    next_phase = 20'h00000;
                    if (why != WHY_MANUAL && tries >= try_limit)
                    begin
                        next_state = ST_IDLE;
                        next_failed = 1'b1;
                    end
                    else
                        next_state = ST_REST;
                end
            end
            ST_REST:
                if (phase >= `REST_SEC)
                begin
                    next_state = ST_START;
                    next_phase = 20'h00000;
                    if (tries != 3'h7)
                        next_tries = tries + 3'h1;
                end
            ST_RUN:
                if (go_stop)
                begin
                    next_state = ST_STOP;
                    next_phase = 20'h00000;
                end
                else if (go_cool)
                begin
                    next_state = ST_COOL;
                    next_phase = 20'h00000;
                end
            ST_COOL:
                if (phase >= 20'(i_cooldown_min) * 20'(`SEC_PER_MIN))
                begin
                    next_state = ST_STOP;
                    next_phase = 20'h00000;
                end
            ST_STOP:
                if (i_run_mode != MODE_GLOW_STOP || phase >= `STOP_PULSE_SEC)
                    next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
        // off overrides everything, no cooldown
        if (i_gen_ctrl == CTRL_OFF && state != ST_IDLE && state != ST_STOP)
        begin
            next_state = ST_STOP;
            next_phase = 20'h00000;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= ST_IDLE;
            why <= WHY_NONE;
            phase <= 20'h00000;
            run_sec <= 20'h00000;
            tries <= 3'h0;
            failed <= 1'b0;
            day_cnt <= 8'h00;
            handover <= 1'b0;
        end
        else
        begin
            state <= next_state;
            why <= next_why;
            phase <= next_phase;
            run_sec <= next_run_sec;
            tries <= next_tries;
            failed <= next_failed;
            day_cnt <= next_day_cnt;
            handover <= next_handover;
        end
    end

    // ==========================================================
    // registered outputs
    logic next_relay;
    logic next_aux;
    logic gen_on;

    // glow-stop closes only to stop; run modes hold closed in start, run and cooldown, open in rest
    always_comb
    begin
        gen_on = state == ST_START || state == ST_REST || state == ST_RUN
                 || state == ST_COOL;
        if (i_run_mode == MODE_GLOW_STOP)
            next_relay = state == ST_STOP;
        else
            next_relay = state == ST_START || state == ST_RUN
                         || state == ST_COOL;
        if (i_aux_mode == AUX_COOLDOWN)
            next_aux = state == ST_COOL;
        else
            next_aux = i_inv_state == INV_ON || i_inv_state == INV_SEARCH;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_gen_run_relay <= 1'b0;
            o_aux_fault_relay <= 1'b0;
            o_manual_start <= 1'b0;
            o_charge_enable <= 1'b1;
            o_cooling <= 1'b0;
            o_running <= 1'b0;
            o_start_failed <= 1'b0;
            o_reason <= WHY_NONE;
        end
        else
        begin
            o_gen_run_relay <= next_relay;
            o_aux_fault_relay <= next_aux;
            o_manual_start <= gen_on && why == WHY_MANUAL;
            o_charge_enable <= !(gen_on && why == WHY_EXERCISE);
            o_cooling <= state == ST_COOL;
            o_running <= state == ST_RUN || state == ST_COOL;
            o_start_failed <= failed;
            o_reason <= gen_on ? why : WHY_NONE;
        end
    end
endmodule

// File: rtl/gen_defs.svh
`ifndef GEN_DEFS_SVH
`define GEN_DEFS_SVH

// ==========================================================
// clock and the common one-second tick
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000000000
`define SEC_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// ==========================================================
// low battery hold times, in their own units
`define LVL0_HOLD_H 24
`define LVL1_HOLD_H 2
`define LVL2_HOLD_MIN 15
`define LVL3_HOLD_S 30
`define SEC_PER_MIN 60
`define SEC_PER_H 3600
`define LVL0_HOLD_SEC 20'(`LVL0_HOLD_H * `SEC_PER_H)
`define LVL1_HOLD_SEC 20'(`LVL1_HOLD_H * `SEC_PER_H)
`define LVL2_HOLD_SEC 20'(`LVL2_HOLD_MIN * `SEC_PER_MIN)
`define LVL3_HOLD_SEC 20'(`LVL3_HOLD_S)

// ==========================================================
// run time that clears the exercise day count
`define RUN_RESET_MIN 5
`define RUN_RESET_SEC 20'(`RUN_RESET_MIN * `SEC_PER_MIN)

// ==========================================================
// settings granularity and day length
`define STEP_MIN 11'h00a
`define MIN_PER_DAY 11'h5a0

// ==========================================================
// start attempts per run mode
`define TRIES_MON 3'h6
`define TRIES_UNMON 3'h1

// ==========================================================
// start and stop sequencing, in seconds
`define ATTEMPT_SEC 20'h0001e
`define REST_SEC 20'h0000a
`define STOP_PULSE_SEC 20'h00002

// ==========================================================
// hold timer channels
`define N_TMR 6
`define TMR_LOAD_HI 4
`define TMR_LOAD_LO 5

`endif

// File: rtl/gen_pkg.sv
package gen_pkg;
    typedef enum logic [1:0] {
        CTRL_OFF = 2'h0,
        CTRL_ON = 2'h1,
        CTRL_AUTO = 2'h2
    } gen_ctrl_t;

    typedef enum logic [1:0] {
        MODE_GLOW_STOP = 2'h0,
        MODE_MON_RUN = 2'h1,
        MODE_UNMON_RUN = 2'h2
    } run_mode_t;

    typedef enum logic [2:0] {
        INV_UNPOWERED = 3'h0,
        INV_OFF = 3'h1,
        INV_ON = 3'h2,
        INV_SEARCH = 3'h3,
        INV_CHARGER = 3'h4,
        INV_BYPASS = 3'h5,
        INV_FAULT = 3'h6
    } inv_state_t;

    typedef enum logic {
        AUX_ERROR = 1'h0,
        AUX_COOLDOWN = 1'h1
    } aux_mode_t;

    typedef enum logic [2:0] {
        WHY_NONE = 3'h0,
        WHY_MANUAL = 3'h1,
        WHY_LOAD = 3'h2,
        WHY_BATT = 3'h3,
        WHY_DAILY = 3'h4,
        WHY_EXERCISE = 3'h5
    } reason_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_REST = 3'h2,
        ST_RUN = 3'h3,
        ST_COOL = 3'h4,
        ST_STOP = 3'h5
    } gen_state_t;
endpackage

// File: rtl/tmr_if.sv
`timescale 1ns/1ps
`include "gen_defs.svh"

interface tmr_if;
    logic tick;
    logic [`N_TMR-1:0] cond;
    logic [19:0] limit [`N_TMR];
    logic [`N_TMR-1:0] done;

    modport ctrl (output tick, output cond, output limit, input done);
    modport bank (input tick, input cond, input limit, output done);
endinterface

// File: rtl/gen_timer_bank.sv
`timescale 1ns/1ps
`include "gen_defs.svh"

module gen_timer_bank (
    input wire logic i_clk, // system clock
    input wire logic i_reset_n, // async reset, active low
    tmr_if.bank bus // hold conditions and limits
);
    // ==========================================================
    // hold timers: each counts seconds while its condition holds
    genvar g;
    generate
        for (g = 0; g < `N_TMR; g++)
        begin : g_tmr
            logic [19:0] cnt;
            logic [19:0] next_cnt;
            logic hit;
            logic next_hit;

            // a dropped condition restarts the hold from zero
            always_comb
            begin
                next_cnt = cnt;
                if (!bus.cond[g])
                    next_cnt = 20'h00000;
                else if (bus.tick && cnt < bus.limit[g])
                    next_cnt = cnt + 20'h00001;
                next_hit = bus.cond[g] && (next_cnt >= bus.limit[g]);
            end

            always_ff @(posedge i_clk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                begin
                    cnt <= 20'h00000;
                    hit <= 1'b0;
                end
                else
                begin
                    cnt <= next_cnt;
                    hit <= next_hit;
                end
            end
            assign bus.done[g] = hit;
        end
    endgenerate
endmodule

// File: verif/gen_model.sv
`timescale 1ns/1ps
// ====================================
// generator seen through its run relay
module gen_model (
    input wire logic i_clk, // clock
    input wire logic i_run, // run relay closed
    input wire logic i_dead, // engine never fires
    output logic o_live // output voltage sensed
);
    logic [2:0] crank;
    // fires after a few cycles of run signal and dies at once when it opens
    always_ff @(posedge i_clk)
    begin
        crank <= i_run ? crank + 3'(crank != 3'h7) : 3'h0;
        o_live <= i_run && !i_dead && crank >= 3'h4;
    end
endmodule

// File: verif/gen_checker.sv
`timescale 1ns/1ps
// ====================================
// port checks for the autostart controller
module gen_checker #(parameter int TICK_CYCLES = 10) (
    input wire logic i_clk, // clock
    input wire logic i_reset_n, // reset
    input wire gen_pkg::gen_ctrl_t i_gen_ctrl, // control
    input wire gen_pkg::run_mode_t i_run_mode, // mode
    input wire gen_pkg::inv_state_t i_inv_state, // inverter
    input wire gen_pkg::aux_mode_t i_aux_mode, // aux mode
    input wire logic o_gen_run_relay, // run relay
    input wire logic o_aux_fault_relay, // aux relay
    input wire logic o_manual_start, // manual
    input wire logic o_charge_enable, // charging
    input wire logic o_cooling, // cooldown
    input wire logic o_running, // running
    input wire logic o_start_failed, // gave up
    input wire gen_pkg::reason_t o_reason // cause
);
    import gen_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // three settled cycles cover the registered relay lag
    sequence s_inv_still;
        (i_aux_mode == AUX_ERROR && $stable(i_inv_state))[*3];
    endsequence
    sequence s_man_req;
        $past(i_gen_ctrl) == CTRL_OFF && i_gen_ctrl == CTRL_ON && i_run_mode != MODE_GLOW_STOP;
    endsequence
    property p_aux_err;
        s_inv_still |-> o_aux_fault_relay == (i_inv_state inside {INV_ON, INV_SEARCH});
    endproperty
    a_aux_err: assert property (p_aux_err) else $error("aux relay");
    property p_man_go;
        s_man_req |-> ##[1:5] o_gen_run_relay && o_manual_start;
    endproperty
    a_man_go: assert property (p_man_go) else $error("manual start");
    property p_off_stop;
        i_gen_ctrl == CTRL_OFF && i_run_mode != MODE_GLOW_STOP |-> ##[1:3] !o_gen_run_relay;
    endproperty
    a_off_stop: assert property (p_off_stop) else $error("off stop");
    property p_man_flag;
        o_manual_start |-> o_reason == WHY_MANUAL;
    endproperty
    a_man_flag: assert property (p_man_flag) else $error("manual flag");
    property p_cool_aux;
        o_cooling && i_aux_mode == AUX_COOLDOWN |-> ##[0:2] o_aux_fault_relay;
    endproperty
    a_cool_aux: assert property (p_cool_aux) else $error("cooldown aux");
    property p_exer;
        o_running && o_reason == WHY_EXERCISE |-> !o_charge_enable;
    endproperty
    a_exer: assert property (p_exer) else $error("exercise charging");
    property p_run_relay;
        $rose(o_running) && i_run_mode != MODE_GLOW_STOP |-> o_gen_run_relay;
    endproperty
    a_run_relay: assert property (p_run_relay) else $error("run relay");
    // an off in the cycle before clears the flag one cycle ahead of the output
    property p_fail_hold;
        o_start_failed && i_gen_ctrl == CTRL_AUTO && $past(i_gen_ctrl) == CTRL_AUTO
            |=> o_start_failed;
    endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("failed flag");
endmodule

bind generator_autostart_controller gen_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

// File: verif/testbench.sv
`timescale 1ns/1ps
// ====================================
// bench top: controller with a generator model behind it
module testbench;
    import gen_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    gen_ctrl_t ctrl = CTRL_OFF;
    run_mode_t mode = MODE_MON_RUN;
    inv_state_t inv = INV_ON;
    aux_mode_t aux = AUX_ERROR;
    logic [15:0] load = 16'h0000, amps = 16'h0064, mv = 16'hffff, lvl = 16'h0000;
    logic [10:0] tod = 11'h000, t_on = 11'h3c0, t_off = 11'h3d4, q_on = 11'h00a;
    logic [10:0] q_off = 11'h014, max_run = 11'h078;
    logic [7:0] one = 8'h01;
    logic dead = 1'b0, grid = 1'b0, chg_done = 1'b0;
    logic live, relay, auxr, man, chg_en, cool, run, failed;
    reason_t why;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, rises = 0;
    wire logic [3:0] st = {failed, relay, cool, run};
    generator_autostart_controller #(.TICK_CYCLES(10)) i_dut (
        .i_clk(clk), .i_reset_n(rst_n), .i_gen_ctrl(ctrl), .i_run_mode(mode),
        .i_inv_state(inv), .i_aux_mode(aux), .i_load_amps(load), .i_load_start_amps(amps),
        .i_load_start_min(one), .i_load_stop_min(one), .i_batt_mv(mv), .i_batt_lvl0(lvl),
        .i_batt_lvl1(lvl), .i_batt_lvl2(lvl), .i_batt_lvl3(lvl), .i_tod_min(tod),
        .i_daily_start_min(t_on), .i_daily_stop_min(t_off), .i_quiet_begin_min(q_on),
        .i_quiet_end_min(q_off), .i_exercise_days(one), .i_exercise_min(one),
        .i_cooldown_min(one), .i_max_run_min(max_run), .i_gen_sensed(live),
        .i_grid_present(grid), .i_charge_done(chg_done), .o_gen_run_relay(relay),
        .o_aux_fault_relay(auxr), .o_manual_start(man), .o_charge_enable(chg_en),
        .o_cooling(cool), .o_running(run), .o_start_failed(failed), .o_reason(why)
    );
    gen_model i_gen (.i_clk(clk), .i_run(relay), .i_dead(dead), .o_live(live));
    // clock, plus a cycle ceiling so a hang still reaches the verdict
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 16000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // one relay rise per start attempt
    always @(posedge relay) rises++;
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait on one status bit; #1 lets the edge's updates land
    task automatic wait_for(int b, logic v, int n);
        for (int k = 0; k < n && st[b] !== v; k++) @(posedge clk);
        #1;
    endtask
    task automatic check_aux_error();
        inv_state_t s [6] = '{INV_ON, INV_SEARCH, INV_CHARGER, INV_OFF, INV_FAULT, INV_UNPOWERED};
        foreach (s[i])
        begin
            @(posedge clk) inv <= s[i];
            settle(4);
            chk("aux", auxr, s[i] inside {INV_ON, INV_SEARCH});
        end
        @(posedge clk) inv <= INV_ON;
    endtask
    task automatic check_manual();
        @(posedge clk) ctrl <= CTRL_ON;
        wait_for(0, 1, 100);
        chk("manual", man, 1);
        chk("why", why, WHY_MANUAL);
        @(posedge clk) ctrl <= CTRL_AUTO;
        settle(50);
        chk("run", run, 1);
        @(posedge clk) chg_done <= 1'b1;
        settle(5);
        chk("cool", cool, 1);
        @(posedge clk) ctrl <= CTRL_OFF;
        settle(4);
        chk("relay", relay, 0);
        @(posedge clk) chg_done <= 1'b0;
    endtask
    task automatic check_load();
        @(posedge clk) ctrl <= CTRL_AUTO;
        aux <= AUX_COOLDOWN;
        load <= 16'h00c8;
        settle(550);
        chk("run", run, 0);
        wait_for(0, 1, 150);
        chk("why", why, WHY_LOAD);
        @(posedge clk) load <= 16'h0000;
        settle(550);
        chk("run", run, 1);
        wait_for(1, 1, 150);
        chk("aux", auxr, 1);
        settle(550);
        chk("relay", relay, 1);
        wait_for(2, 0, 150);
        chk("relay", relay, 0);
    endtask
    // engine that never fires: attempts run out and the flag sticks
    task automatic check_retries();
        rises = 0;
        @(posedge clk) dead <= 1'b1;
        load <= 16'h00c8;
        wait_for(3, 1, 4000);
        chk("failed", failed, 1);
        chk("attempts", rises[7:0], 8'h06);
        @(posedge clk) ctrl <= CTRL_OFF;
        dead <= 1'b0;
        load <= 16'h0000;
    endtask
    task automatic check_exercise();
        @(posedge clk) ctrl <= CTRL_AUTO;
        tod <= 11'h59f;
        settle(3);
        @(posedge clk) tod <= 11'h000;
        settle(3);
        @(posedge clk) tod <= q_off;
        wait_for(0, 1, 100);
        chk("why", why, WHY_EXERCISE);
        chk("charge", chg_en, 0);
        settle(640);
        chk("relay", relay, 0);
    endtask
    // daily start, then a grid source sends the run into cooldown
    task automatic check_daily();
        @(posedge clk) tod <= t_on;
        wait_for(0, 1, 100);
        chk("why", why, WHY_DAILY);
        @(posedge clk) grid <= 1'b1;
        wait_for(1, 1, 20);
        chk("cool", cool, 1);
        @(posedge clk) ctrl <= CTRL_OFF;
        grid <= 1'b0;
        settle(4);
        chk("relay", relay, 0);
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        settle(2);
        check_aux_error();
        check_manual();
        check_load();
        check_retries();
        check_exercise();
        check_daily();
        tally_and_finish();
    end
endmodule
